// *** cdt_timer_top.sv ***
`timescale 1ns/1ps
module cdt_timer_top
  import cdt_pkg::*;
#(
  parameter int NUM_TIMERS = CDT_NUM_TIMERS
) (
  // Clock and reset
  input  wire logic                                 ref_clk_i,
  input  wire logic                                 reset_i,
  // Software register writes
  input  wire logic [NUM_TIMERS-1:0]                count_wr_i,
  input  wire logic [NUM_TIMERS-1:0]                reload_wr_i,
  input  wire logic [CDT_TIMER_W-1:0]               wdata_i,
  input  wire logic                                 ctrl_wr_i,
  input  wire logic [NUM_TIMERS-1:0]                ctrl_enable_i,
  input  wire logic [NUM_TIMERS-1:0]                ctrl_autoreload_i,
  input  wire logic [NUM_TIMERS/2-1:0]              ctrl_cascade_i,
  // Register read-back
  output logic      [NUM_TIMERS-1:0][CDT_TIMER_W-1:0] count_o,
  output logic      [NUM_TIMERS-1:0][CDT_TIMER_W-1:0] reload_o,
  output logic      [NUM_TIMERS-1:0]                enable_o,
  output logic      [NUM_TIMERS-1:0]                autoreload_o,
  output logic      [NUM_TIMERS/2-1:0]              cascade_o,
  // Interrupt requests
  output logic      [NUM_TIMERS-1:0]                irq_o
);

  localparam int NP = NUM_TIMERS / 2;

  if (NUM_TIMERS < 2 || (NUM_TIMERS % 2) != 0) begin : g_bad_count
    $error("NUM_TIMERS must be even and at least 2");
  end

  typedef struct packed {
    logic [NUM_TIMERS-1:0][CDT_TIMER_W-1:0] count;
    logic [NUM_TIMERS-1:0][CDT_TIMER_W-1:0] reload;
    logic [NUM_TIMERS-1:0]                  enable;
    logic [NUM_TIMERS-1:0]                  autoreload;
    logic [NP-1:0]                          cascade;
    logic [NUM_TIMERS-1:0]                  irq;
  } cdt_state_t;

  cdt_state_t              s;
  cdt_state_t              next_s;
  logic [NUM_TIMERS-1:0]   shot_clear;
  logic [2*CDT_TIMER_W-1:0] pair_val;
  cdt_tick_if              tick_if ();

  cdt_prescaler u_prescaler (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .tick_if   (tick_if.src)
  );

  always_comb begin
    next_s     = s;
    next_s.irq = '0;
    shot_clear = '0;
    pair_val   = '0;
    if (tick_if.tick) begin
      for (int p = 0; p < NP; p++) begin
        if (s.cascade[p]) begin
          // The cascaded pair timer runs on the even timer's enable
          pair_val = {s.count[2*p+1], s.count[2*p]};
          if (s.enable[2*p]) begin
            if (pair_val <= CDT_PAIR_ONE) begin
              next_s.irq[2*p]       = 1'b1;
              next_s.count[2*p+1]   = s.reload[2*p+1];
              next_s.count[2*p]     = s.reload[2*p];
            end else begin
              {next_s.count[2*p+1], next_s.count[2*p]} = pair_val - CDT_PAIR_ONE;
            end
          end
        end else begin
          for (int j = 0; j < 2; j++) begin
            if (s.enable[2*p+j]) begin
              // Enabled timers start from the count they hold
              if (s.count[2*p+j] <= CDT_BYTE_ONE) begin
                next_s.irq[2*p+j] = 1'b1;
                if (s.autoreload[2*p+j]) begin
                  next_s.count[2*p+j] = s.reload[2*p+j];
                end else begin
                  next_s.count[2*p+j] = CDT_COUNT_RST;
                  shot_clear[2*p+j]   = 1'b1;
                end
              end else begin
                next_s.count[2*p+j] = s.count[2*p+j] - CDT_BYTE_ONE;
              end
            end
          end
        end
      end
    end
    // Software writes land after the writeback so they win; a single-shot stop still clears enable
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (count_wr_i[i]) begin
        next_s.count[i] = wdata_i;
      end
      if (reload_wr_i[i]) begin
        next_s.reload[i] = wdata_i;
      end
    end
    if (ctrl_wr_i) begin
      next_s.enable     = ctrl_enable_i;
      next_s.autoreload = ctrl_autoreload_i;
      next_s.cascade    = ctrl_cascade_i;
    end
    next_s.enable = next_s.enable & ~shot_clear;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s         <= '0;
      s.count   <= {NUM_TIMERS{CDT_COUNT_RST}};
      s.reload  <= {NUM_TIMERS{CDT_RELOAD_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign count_o      = s.count;
  assign reload_o     = s.reload;
  assign enable_o     = s.enable;
  assign autoreload_o = s.autoreload;
  assign cascade_o    = s.cascade;
  assign irq_o        = s.irq;

  a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!s.enable[0] && !s.cascade[0] && !count_wr_i[0]) |=> $stable(count_o[0]))
    else $error("idle timer count changed");

  a_dec_step: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.enable[0] && !s.cascade[0] && s.count[0] > CDT_BYTE_ONE
     && !count_wr_i[0]) |=> count_o[0] == $past(count_o[0]) - CDT_BYTE_ONE)
    else $error("timer did not decrement by one");

  a_irq_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.enable[0] && !s.cascade[0] && s.count[0] <= CDT_BYTE_ONE)
    |=> irq_o[0] ##1 !irq_o[0])
    else $error("zero did not raise a one-cycle interrupt");

  a_reload_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.enable[0] && !s.cascade[0] && s.autoreload[0]
     && s.count[0] <= CDT_BYTE_ONE && !count_wr_i[0] && !reload_wr_i[0] && !ctrl_wr_i)
    |=> count_o[0] == reload_o[0] && enable_o[0])
    else $error("auto-reload did not copy reload value");

  a_single_stop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.enable[0] && !s.cascade[0] && !s.autoreload[0]
     && s.count[0] <= CDT_BYTE_ONE) |=> !enable_o[0])
    else $error("single-shot timer kept its enable");

  a_casc_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.cascade[0] && s.enable[0]
     && {s.count[1], s.count[0]} <= CDT_PAIR_ONE) |=> irq_o[0] && !irq_o[1])
    else $error("cascaded pair interrupt not on even timer");

  a_casc_reload: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.cascade[0] && s.enable[0] && {s.count[1], s.count[0]} <= CDT_PAIR_ONE
     && count_wr_i[1:0] == 2'h0 && reload_wr_i[1:0] == 2'h0 && !ctrl_wr_i)
    |=> {count_o[1], count_o[0]} == {reload_o[1], reload_o[0]} && enable_o[0])
    else $error("cascaded pair did not reload and run on");

  a_casc_carry: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tick_if.tick && s.cascade[0] && s.enable[0] && s.count[0] == CDT_COUNT_RST
     && s.count[1] != CDT_COUNT_RST && count_wr_i[1:0] == 2'h0)
    |=> count_o[1] == $past(count_o[1]) - CDT_BYTE_ONE && count_o[0] == 8'hFF)
    else $error("low byte did not borrow from high byte");

  a_sw_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    count_wr_i[0] |=> count_o[0] == $past(wdata_i))
    else $error("software count write lost");

  a_tick_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!tick_if.tick && !count_wr_i[0]) |=> $stable(count_o[0]))
    else $error("count moved off a tick");

endmodule

// *** cdt_pkg.sv ***
package cdt_pkg;

  localparam int           CDT_TIMER_W     = 8;
  localparam int           CDT_NUM_TIMERS  = 4;
  localparam int           CDT_PRESCALE    = 8;
  localparam int           CDT_PRESCALE_W  = 3;
  localparam logic [2:0]   CDT_PRESCALE_LAST = 3'h7;
  localparam logic [7:0]   CDT_COUNT_RST   = 8'h00;
  localparam logic [7:0]   CDT_RELOAD_RST  = 8'h00;
  localparam logic [15:0]  CDT_PAIR_ONE    = 16'h0001;
  localparam logic [7:0]   CDT_BYTE_ONE    = 8'h01;

endpackage

// *** cdt_tick_if.sv ***
`timescale 1ns/1ps
interface cdt_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input  tick);
endinterface

// *** cdt_prescaler.sv ***
`timescale 1ns/1ps
module cdt_prescaler
  import cdt_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Tick out
  cdt_tick_if.src   tick_if
);

  typedef struct packed {
    logic [CDT_PRESCALE_W-1:0] cnt;
    logic                      tick;
  } cdt_pre_state_t;

  cdt_pre_state_t s;
  cdt_pre_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.cnt  = s.cnt + 3'h1;
    next_s.tick = (s.cnt == CDT_PRESCALE_LAST);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_if.tick = s.tick;

  // One tick in every eighth clock
  a_tick_period: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s.tick |=> !s.tick [*7] ##1 s.tick)
    else $error("tick period is not eight clocks");

endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import cdt_pkg::*;
  typedef struct {logic [3:0] irq; logic [7:0] cnt; int idx;} cdt_note_t;
  logic                   ref_clk_i, reset_i, ctrl_wr_i;
  logic [3:0]             count_wr_i, reload_wr_i, ctrl_enable_i, ctrl_autoreload_i;
  logic [1:0]             ctrl_cascade_i, cascade_o;
  logic [7:0]             wdata_i;
  logic [3:0][7:0]        count_o, reload_o;
  logic [3:0]             enable_o, autoreload_o, irq_o;
  cdt_note_t              notes[$];
  cdt_note_t              nt;
  int                     n_mismatch, tests_run, n, r;
  cdt_timer_top #(.NUM_TIMERS(4)) cdt_timer_top_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .count_wr_i(count_wr_i),
    .reload_wr_i(reload_wr_i), .wdata_i(wdata_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_enable_i(ctrl_enable_i), .ctrl_autoreload_i(ctrl_autoreload_i),
    .ctrl_cascade_i(ctrl_cascade_i), .count_o(count_o), .reload_o(reload_o),
    .enable_o(enable_o), .autoreload_o(autoreload_o), .cascade_o(cascade_o),
    .irq_o(irq_o));
  initial ref_clk_i = 1'b0;
  always #10 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Each write strobes for one edge; caller stands at a falling edge
  task automatic wr(input int kind, input int i, input logic [7:0] d);
    wdata_i = d;
    if (kind == 0) count_wr_i = 4'h1 << i;
    else reload_wr_i = 4'h1 << i;
    @(negedge ref_clk_i);
    count_wr_i = 4'h0;
    reload_wr_i = 4'h0;
    check(kind == 0 ? count_o[i] : reload_o[i], d);
  endtask
  task automatic wr_ctrl(input logic [3:0] en, input logic [3:0] ar, input logic [1:0] cs);
    ctrl_wr_i = 1'b1;
    ctrl_enable_i = en;
    ctrl_autoreload_i = ar;
    ctrl_cascade_i = cs;
    @(negedge ref_clk_i);
    ctrl_wr_i = 1'b0;
  endtask
  task automatic wait_irq(input int i, input int lim);
    n = 0;
    while (irq_o[i] !== 1'b1 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= lim) begin
      check(1, 0);
      end_sim();
    end
    @(negedge ref_clk_i);
  endtask
  // Every interrupt pulse must match the oldest note
  always @(negedge ref_clk_i) begin
    if (!reset_i && irq_o !== 4'h0) begin
      if (notes.size() == 0) check(irq_o, 0);
      else begin
        nt = notes.pop_front();
        check(irq_o, nt.irq);
        check(count_o[nt.idx], nt.cnt);
      end
    end
  end
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(32'h1d02ebab));
    {reset_i, ctrl_wr_i, count_wr_i, reload_wr_i, wdata_i} = {1'b1, 17'h0};
    {ctrl_enable_i, ctrl_autoreload_i, ctrl_cascade_i} = 10'h0;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    check(count_o, 0);
    check(reload_o, 0);
    check({enable_o, autoreload_o, cascade_o, irq_o}, 0);
    // Timer registers are written for timing use, and wr reads each write back
    // Auto-reload: starts from count 2, not from reload value
    r = $urandom_range(4, 9);
    wr(0, 0, 8'h02);
    wr(1, 0, r[7:0]);
    notes.push_back('{4'h1, r[7:0], 0});
    notes.push_back('{4'h1, r[7:0], 0});
    wr_ctrl(4'h1, 4'h1, 2'h0);
    check(autoreload_o, 4'h1);
    wait_irq(0, 40);
    check(n < 24, 1);
    wait_irq(0, 100);
    check(n + 1, r * 8);
    // Single-shot on timer 1
    wr(0, 1, 8'h03);
    notes.push_back('{4'h2, 8'h00, 1});
    wr_ctrl(4'h2, 4'h1, 2'h0);
    wait_irq(1, 40);
    check(enable_o, 4'h0);
    repeat (40) @(negedge ref_clk_i);
    check(count_o[1], 8'h00);
    // Cascaded pair 0/1: value 0101, reload 0102
    wr(0, 0, 8'h01);
    wr(0, 1, 8'h01);
    wr(1, 0, 8'h02);
    wr(1, 1, 8'h01);
    wr_ctrl(4'h1, 4'h0, 2'h1);
    check(cascade_o, 2'h1);
    n = 0;
    while (count_o[0] !== 8'hFF && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({count_o[1], count_o[0]}, 16'h00FF);
    notes.push_back('{4'h1, 8'h02, 0});
    wait_irq(0, 2100);
    check({count_o[1], count_o[0]}, 16'h0102);
    check(enable_o[0], 1'b1);
    wr_ctrl(4'h0, 4'h0, 2'h0);
    repeat (10) @(negedge ref_clk_i);
    check(notes.size(), 0);
    end_sim();
  end
endmodule
